// >>> core/ata_cmd_pkg.sv
package ata_cmd_pkg;

  // task file offsets
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_ERROR = 3'h1;
  localparam logic [2:0] REG_SECTOR_COUNT = 3'h2;
  localparam logic [2:0] REG_SECTOR_NUMBER = 3'h3;
  localparam logic [2:0] REG_CYLINDER_LOW = 3'h4;
  localparam logic [2:0] REG_CYLINDER_HIGH = 3'h5;
  localparam logic [2:0] REG_DRIVE_HEAD = 3'h6;
  localparam logic [2:0] REG_COMMAND_STATUS = 3'h7;

  // opcodes
  localparam logic [7:0] OP_IDLE_A = 8'h97;
  localparam logic [7:0] OP_IDLE_B = 8'hE3;
  localparam logic [7:0] OP_IDLE_NOW_A = 8'h95;
  localparam logic [7:0] OP_IDLE_NOW_B = 8'hE1;
  localparam logic [7:0] OP_INIT_PARAMS = 8'h91;
  localparam logic [7:0] OP_READ_BUFFER = 8'hE4;
  localparam logic [7:0] OP_READ_DMA = 8'hC8;
  localparam logic [7:0] OP_READ_LONG_A = 8'h22;
  localparam logic [7:0] OP_READ_LONG_B = 8'h23;
  localparam logic [7:0] OP_READ_A = 8'h20;
  localparam logic [7:0] OP_READ_B = 8'h21;
  localparam logic [7:0] OP_VERIFY_A = 8'h40;
  localparam logic [7:0] OP_VERIFY_B = 8'h41;
  localparam logic [3:0] OP_RECAL_HI = 4'h1;
  localparam logic [7:0] OP_SENSE = 8'h03;

  // status and error bit positions
  localparam int ST_BUSY_BIT = 7;
  localparam int ST_READY_BIT = 6;
  localparam int ST_SEEK_DONE_BIT = 4;
  localparam int ST_DRQ_BIT = 3;
  localparam int ST_ERR_BIT = 0;
  localparam int ERR_ABORT_BIT = 2;
  localparam int ERR_UNCORR_BIT = 6;
  localparam int DH_LINEAR_BIT = 6;

  // extended error codes
  localparam logic [7:0] EXT_NONE = 8'h00;
  localparam logic [7:0] EXT_SELF_TEST_OK = 8'h01;
  localparam logic [7:0] EXT_MISC = 8'h09;
  localparam logic [7:0] EXT_INVALID_CMD = 8'h20;
  localparam logic [7:0] EXT_INVALID_ADDR = 8'h21;
  localparam logic [7:0] EXT_ADDR_OVERFLOW = 8'h2F;
  localparam logic [7:0] EXT_UNCORR_ECC = 8'h11;
  localparam logic [7:0] EXT_CORR_ECC = 8'h18;
  localparam logic [7:0] EXT_ABORTED = 8'h1F;
  localparam logic [7:0] EXT_ID_NOT_FOUND = 8'h10;
  localparam logic [7:0] EXT_WRITE_FAIL = 8'h03;
  localparam logic [7:0] EXT_SPARES_GONE = 8'h3A;
  localparam logic [7:0] EXT_POWER_L1_OFF = 8'h22;

  // sizes
  localparam int SECTOR_WORDS = 256;
  localparam logic [8:0] LAST_WORD = 9'h0FF;
  localparam logic [8:0] LAST_LONG_WORD = 9'h103;

  // reset values
  localparam logic [7:0] TASK_RST = 8'h00;
  localparam logic [7:0] DRIVE_HEAD_RST = 8'hA0;
  localparam logic [7:0] SPT_RST = 8'h3F;
  localparam logic [3:0] MAX_HEAD_RST = 4'hF;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PD_STEP_MS = 5;
  localparam int PD_STEP_CYCLES = PD_STEP_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_FETCH = 2'b01,
    S_XFER = 2'b11,
    S_FINISH = 2'b10
  } state_e;

  typedef enum logic [2:0] {
    K_PIO = 3'h0,
    K_DMA = 3'h1,
    K_LONG = 3'h2,
    K_VERIFY = 3'h3,
    K_BUF = 3'h4
  } kind_e;

endpackage

// >>> core/sector_buffer.sv
`timescale 1ns/10ps
`default_nettype none
module sector_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  // clock
  input wire logic i_sys_clk,
  input wire logic i_clk_en,
  // write side
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [WIDTH-1:0] i_wr_data,
  // read side
  input wire logic [AW-1:0] i_rd_addr,
  output logic [WIDTH-1:0] o_rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // no reset on the array; read data always registered
  always_ff @(posedge i_sys_clk) begin
    if (i_clk_en) begin
      if (i_wr_en) begin
        mem[i_wr_addr] <= i_wr_data;
      end
      o_rd_data <= mem[i_rd_addr];
    end
  end

endmodule // sector_buffer
`default_nettype wire

// >>> core/power_down_timer.sv
`timescale 1ns/10ps
`default_nettype none
module power_down_timer import ata_cmd_pkg::*; #(
  parameter int unsigned STEP_CYCLES = PD_STEP_CYCLES
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  // control
  input wire logic i_arm,
  input wire logic i_disarm,
  input wire logic i_wake,
  input wire logic [7:0] i_steps,
  // state
  output logic o_power_down
);

  localparam int TW = $clog2(STEP_CYCLES + 1);

  logic armed, next_armed;
  logic [7:0] steps, next_steps;
  logic [7:0] left, next_left;
  logic [TW-1:0] tick, next_tick;
  logic next_power_down;

  always_comb begin
    next_armed = armed;
    next_steps = steps;
    next_left = left;
    next_tick = tick;
    next_power_down = o_power_down;
    if (i_arm) begin
      next_armed = 1'b1;
      next_steps = i_steps;
      next_left = i_steps;
      next_tick = '0;
      next_power_down = 1'b0;
    end else if (i_disarm) begin
      next_armed = 1'b0;
      next_power_down = 1'b0;
    end else if (i_wake) begin
      // an accepted host task file write restarts the full timeout; host reads do not
      next_left = steps;
      next_tick = '0;
      next_power_down = 1'b0;
    end else if (armed && !o_power_down) begin
      if (tick == TW'(STEP_CYCLES - 1)) begin
        next_tick = '0;
        next_left = left - 8'h01;
        if (left == 8'h01) begin
          next_power_down = 1'b1;
        end
      end else begin
        next_tick = tick + TW'(1);
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      armed <= 1'b0;
      steps <= 8'h00;
      left <= 8'h00;
      tick <= '0;
      o_power_down <= 1'b0;
    end else if (i_clk_en) begin
      armed <= next_armed;
      steps <= next_steps;
      left <= next_left;
      tick <= next_tick;
      o_power_down <= next_power_down;
    end
  end

endmodule // power_down_timer
`default_nettype wire

// >>> core/ata_read_idle_command_set.sv
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - idle opcodes go busy, finish with interrupt; nonzero count arms 5 ms-step power-down
// - idle with zero count turns automatic power-down off
// - idle-immediate opcodes go busy, finish with interrupt, use no operands
// - init parameters takes sectors per track and max head, nothing else
// - read buffer offers current buffer contents like a one-sector read
// - dma read moves 1 to 256 sectors, zero meaning 256, from addressed sector
// - dma read buffers while busy, then drq and transfer request while data waits
// - dma read interrupts once at end or on error, never per sector
// - failing dma read stops there, task file holds failing address
// - dma read aborts when 8-bit transfer mode is enabled
// - read long gives 512 data bytes as words then 4 ecc bytes
// - sector read moves 1 to 256 sectors; task file ends on last sector
// - each buffered sector sets drq, clears busy, interrupts; host reads 512 bytes
// - sector read error stops, loads failing address, leaves data in buffer
// - verify reads like sector read without drq or data, then interrupts
// - verify leaves last address, or failing address and unverified count
// - opcodes 1Xh complete as no-operation without side effects
// - request sense puts previous extended error code into error register
// - extended codes for command, address and media faults
// - extended codes for ecc, transfer and abort faults
// - multiple-block mode off after reset and soft reset unless kept
module ata_read_idle_command_set import ata_cmd_pkg::*; #(
  parameter int unsigned STEP_CYCLES = PD_STEP_CYCLES
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  // register port
  input wire logic [2:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // host interrupt and dma pins
  output logic o_intrq,
  output logic o_transfer_request_line,
  input wire logic i_transfer_grant_line_n,
  input wire logic i_io_read_strobe_n,
  output logic [15:0] o_dma_data,
  // media side
  output logic o_media_rd,
  output logic [31:0] o_media_addr,
  input wire logic i_media_wvalid,
  input wire logic [15:0] i_media_wdata,
  input wire logic i_media_done,
  input wire logic i_media_err,
  input wire logic [7:0] i_media_err_code,
  input wire logic [31:0] i_media_ecc,
  // configuration and power
  input wire logic i_eight_bit_mode,
  input wire logic i_soft_reset,
  input wire logic i_keep_on_soft_reset,
  output logic o_multiple_en,
  output logic [7:0] o_sectors_per_track,
  output logic [3:0] o_max_head,
  output logic o_power_down
);

  state_e state, next_state;
  kind_e kind, next_kind;
  logic [8:0] remaining, next_remaining;
  logic [8:0] rd_idx, next_rd_idx;
  logic [7:0] wr_idx, next_wr_idx;
  logic [7:0] sec_cnt, next_sec_cnt;
  logic [7:0] sec_num, next_sec_num;
  logic [7:0] cyl_lo, next_cyl_lo;
  logic [7:0] cyl_hi, next_cyl_hi;
  logic [7:0] drv_head, next_drv_head;
  logic busy, next_busy;
  logic drq, next_drq;
  logic err_st, next_err_st;
  logic [7:0] err_reg, next_err_reg;
  logic [7:0] ext_err, next_ext_err;
  logic [31:0] ecc, next_ecc;
  logic next_intrq, next_dma_req, next_media_rd, next_multiple_en;
  logic [15:0] next_rdata, next_dma_data;
  logic [7:0] next_spt;
  logic [3:0] next_max_head;

  logic grant_s1, grant_s2, strobe_s1, strobe_s2, strobe_s3;
  logic [15:0] buf_q;
  logic tmr_arm, tmr_disarm, tmr_wake;
  logic pop, last_word, strobe_fall;
  logic [8:0] count_full;
  logic [27:0] lba_next;
  logic [7:0] adv_sec, adv_cyl_lo, adv_cyl_hi, adv_dh;
  logic [15:0] adv_cyl;

  // pins from the host are asynchronous; two stages before use
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      grant_s1 <= 1'b1;
      grant_s2 <= 1'b1;
      strobe_s1 <= 1'b1;
      strobe_s2 <= 1'b1;
      strobe_s3 <= 1'b1;
    end else if (i_clk_en) begin
      grant_s1 <= i_transfer_grant_line_n;
      grant_s2 <= grant_s1;
      strobe_s1 <= i_io_read_strobe_n;
      strobe_s2 <= strobe_s1;
      strobe_s3 <= strobe_s2;
    end
  end

  assign strobe_fall = strobe_s3 && !strobe_s2;
  assign count_full = {sec_cnt == 8'h00, sec_cnt};
  assign last_word = (kind == K_LONG) ? (rd_idx == LAST_LONG_WORD) : (rd_idx == LAST_WORD);

  // address of the following sector, linear or geometric
  always_comb begin
    lba_next = {drv_head[3:0], cyl_hi, cyl_lo, sec_num} + 28'h0000001;
    adv_cyl = {cyl_hi, cyl_lo};
    adv_dh = drv_head;
    adv_sec = sec_num + 8'h01;
    if (drv_head[DH_LINEAR_BIT]) begin
      adv_sec = lba_next[7:0];
      adv_cyl = lba_next[23:8];
      adv_dh = {drv_head[7:4], lba_next[27:24]};
    end else if (sec_num >= o_sectors_per_track) begin
      adv_sec = 8'h01;
      if (drv_head[3:0] >= o_max_head) begin
        adv_dh = {drv_head[7:4], 4'h0};
        adv_cyl = {cyl_hi, cyl_lo} + 16'h0001;
      end else begin
        adv_dh = {drv_head[7:4], drv_head[3:0] + 4'h1};
      end
    end
    adv_cyl_lo = adv_cyl[7:0];
    adv_cyl_hi = adv_cyl[15:8];
  end

  // a word leaves the buffer on a data read or a granted strobe
  always_comb begin
    pop = 1'b0;
    if (state == S_XFER) begin
      if (kind == K_DMA) begin
        pop = strobe_fall && !grant_s2;
      end else begin
        pop = i_rd && (i_addr == REG_DATA);
      end
    end
  end

  always_comb begin
    next_state = state;
    next_kind = kind;
    next_remaining = remaining;
    next_rd_idx = rd_idx;
    next_wr_idx = wr_idx;
    next_sec_cnt = sec_cnt;
    next_sec_num = sec_num;
    next_cyl_lo = cyl_lo;
    next_cyl_hi = cyl_hi;
    next_drv_head = drv_head;
    next_busy = busy;
    next_drq = drq;
    next_err_st = err_st;
    next_err_reg = err_reg;
    next_ext_err = ext_err;
    next_ecc = ecc;
    next_intrq = o_intrq;
    next_dma_req = o_transfer_request_line;
    next_media_rd = o_media_rd;
    next_multiple_en = o_multiple_en;
    next_spt = o_sectors_per_track;
    next_max_head = o_max_head;
    next_rdata = o_rdata;
    next_dma_data = buf_q;
    tmr_arm = 1'b0;
    tmr_disarm = 1'b0;
    tmr_wake = 1'b0;

    // reads; the status read clears the pending interrupt
    if (i_rd) begin
      unique case (i_addr)
        REG_DATA: begin
          if (state == S_XFER && rd_idx[8]) begin
            next_rdata = {8'h00, ecc[8*rd_idx[1:0] +: 8]};
          end else begin
            next_rdata = buf_q;
          end
        end
        REG_ERROR: next_rdata = {8'h00, err_reg};
        REG_SECTOR_COUNT: next_rdata = {8'h00, sec_cnt};
        REG_SECTOR_NUMBER: next_rdata = {8'h00, sec_num};
        REG_CYLINDER_LOW: next_rdata = {8'h00, cyl_lo};
        REG_CYLINDER_HIGH: next_rdata = {8'h00, cyl_hi};
        REG_DRIVE_HEAD: next_rdata = {8'h00, drv_head};
        REG_COMMAND_STATUS: begin
          next_rdata = 16'h0000;
          next_rdata[ST_BUSY_BIT] = busy;
          next_rdata[ST_READY_BIT] = 1'b1;
          next_rdata[ST_SEEK_DONE_BIT] = 1'b1;
          next_rdata[ST_DRQ_BIT] = drq;
          next_rdata[ST_ERR_BIT] = err_st;
          next_intrq = 1'b0;
        end
      endcase
    end

    // task file writes are ignored while busy or offering data
    if (i_wr && !busy && !drq) begin
      tmr_wake = 1'b1;
      unique case (i_addr)
        REG_SECTOR_COUNT: next_sec_cnt = i_wdata[7:0];
        REG_SECTOR_NUMBER: next_sec_num = i_wdata[7:0];
        REG_CYLINDER_LOW: next_cyl_lo = i_wdata[7:0];
        REG_CYLINDER_HIGH: next_cyl_hi = i_wdata[7:0];
        REG_DRIVE_HEAD: next_drv_head = i_wdata[7:0];
        REG_COMMAND_STATUS: begin
          next_busy = 1'b1;
          next_err_st = 1'b0;
          next_err_reg = 8'h00;
          next_ext_err = EXT_NONE;
          next_intrq = 1'b0;
          next_rd_idx = 9'h000;
          next_wr_idx = 8'h00;
          next_remaining = count_full;
          next_state = S_FINISH;
          if (i_wdata[7:4] == OP_RECAL_HI) begin
            next_state = S_FINISH;
          end else begin
            unique case (i_wdata[7:0])
              OP_IDLE_A, OP_IDLE_B: begin
                tmr_arm = sec_cnt != 8'h00;
                tmr_disarm = sec_cnt == 8'h00;
              end
              OP_IDLE_NOW_A, OP_IDLE_NOW_B: next_state = S_FINISH;
              OP_INIT_PARAMS: begin
                next_spt = sec_cnt;
                next_max_head = drv_head[3:0];
              end
              OP_READ_BUFFER: begin
                next_kind = K_BUF;
                next_remaining = 9'h001;
                next_state = S_XFER;
                next_busy = 1'b0;
                next_drq = 1'b1;
                next_intrq = 1'b1;
              end
              OP_READ_DMA: begin
                if (i_eight_bit_mode) begin
                  next_err_st = 1'b1;
                  next_err_reg[ERR_ABORT_BIT] = 1'b1;
                  next_ext_err = EXT_ABORTED;
                end else begin
                  next_kind = K_DMA;
                  next_state = S_FETCH;
                end
              end
              OP_READ_LONG_A, OP_READ_LONG_B: begin
                next_kind = K_LONG;
                next_remaining = 9'h001;
                next_state = S_FETCH;
              end
              OP_READ_A, OP_READ_B: begin
                next_kind = K_PIO;
                next_state = S_FETCH;
              end
              OP_VERIFY_A, OP_VERIFY_B: begin
                next_kind = K_VERIFY;
                next_state = S_FETCH;
              end
              OP_SENSE: next_err_reg = ext_err;
              default: begin
                next_err_st = 1'b1;
                next_err_reg[ERR_ABORT_BIT] = 1'b1;
                next_ext_err = EXT_INVALID_CMD;
              end
            endcase
          end
        end
        default: ;
      endcase
    end

    unique case (state)
      S_IDLE: ;
      S_FETCH: begin
        next_media_rd = !i_media_done;
        if (i_media_wvalid) begin
          next_wr_idx = wr_idx + 8'h01;
        end
        if (i_media_done) begin
          next_wr_idx = 8'h00;
          next_ecc = i_media_ecc;
          if (i_media_err) begin
            // address already names the failing sector
            next_err_st = 1'b1;
            next_err_reg[ERR_UNCORR_BIT] = 1'b1;
            next_ext_err = i_media_err_code;
            next_state = S_FINISH;
            if (kind == K_VERIFY) begin
              next_sec_cnt = remaining[7:0];
            end
          end else if (kind == K_VERIFY) begin
            if (remaining == 9'h001) begin
              next_state = S_FINISH;
            end else begin
              next_remaining = remaining - 9'h001;
              next_sec_num = adv_sec;
              next_cyl_lo = adv_cyl_lo;
              next_cyl_hi = adv_cyl_hi;
              next_drv_head = adv_dh;
            end
          end else begin
            next_state = S_XFER;
            next_busy = 1'b0;
            next_drq = 1'b1;
            next_rd_idx = 9'h000;
            if (kind == K_DMA) begin
              next_dma_req = 1'b1;
            end else begin
              next_intrq = 1'b1;
            end
          end
        end
      end
      S_XFER: begin
        if (pop) begin
          next_rd_idx = rd_idx + 9'h001;
          if (last_word) begin
            next_rd_idx = 9'h000;
            next_drq = 1'b0;
            next_dma_req = 1'b0;
            if (remaining == 9'h001) begin
              // last pio sector needs no further interrupt
              next_state = (kind == K_DMA) ? S_FINISH : S_IDLE;
              next_busy = kind == K_DMA;
            end else begin
              next_remaining = remaining - 9'h001;
              next_sec_num = adv_sec;
              next_cyl_lo = adv_cyl_lo;
              next_cyl_hi = adv_cyl_hi;
              next_drv_head = adv_dh;
              next_busy = 1'b1;
              next_state = S_FETCH;
            end
          end
        end
      end
      S_FINISH: begin
        next_busy = 1'b0;
        next_intrq = 1'b1;
        next_state = S_IDLE;
      end
    endcase

    if (i_soft_reset) begin
      next_state = S_IDLE;
      next_busy = 1'b0;
      next_drq = 1'b0;
      next_dma_req = 1'b0;
      next_media_rd = 1'b0;
      next_intrq = 1'b0;
      if (!i_keep_on_soft_reset) begin
        next_multiple_en = 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= S_IDLE;
      kind <= K_PIO;
      remaining <= 9'h000;
      rd_idx <= 9'h000;
      wr_idx <= 8'h00;
      sec_cnt <= TASK_RST;
      sec_num <= TASK_RST;
      cyl_lo <= TASK_RST;
      cyl_hi <= TASK_RST;
      drv_head <= DRIVE_HEAD_RST;
      busy <= 1'b0;
      drq <= 1'b0;
      err_st <= 1'b0;
      err_reg <= 8'h00;
      ext_err <= EXT_NONE;
      ecc <= 32'h00000000;
      o_intrq <= 1'b0;
      o_transfer_request_line <= 1'b0;
      o_media_rd <= 1'b0;
      o_multiple_en <= 1'b0;
      o_sectors_per_track <= SPT_RST;
      o_max_head <= MAX_HEAD_RST;
      o_rdata <= 16'h0000;
      o_dma_data <= 16'h0000;
    end else if (i_clk_en) begin
      state <= next_state;
      kind <= next_kind;
      remaining <= next_remaining;
      rd_idx <= next_rd_idx;
      wr_idx <= next_wr_idx;
      sec_cnt <= next_sec_cnt;
      sec_num <= next_sec_num;
      cyl_lo <= next_cyl_lo;
      cyl_hi <= next_cyl_hi;
      drv_head <= next_drv_head;
      busy <= next_busy;
      drq <= next_drq;
      err_st <= next_err_st;
      err_reg <= next_err_reg;
      ext_err <= next_ext_err;
      ecc <= next_ecc;
      o_intrq <= next_intrq;
      o_transfer_request_line <= next_dma_req;
      o_media_rd <= next_media_rd;
      o_multiple_en <= next_multiple_en;
      o_sectors_per_track <= next_spt;
      o_max_head <= next_max_head;
      o_rdata <= next_rdata;
      o_dma_data <= next_dma_data;
    end
  end

  assign o_media_addr = {drv_head, cyl_hi, cyl_lo, sec_num};

  // buffer read address looks one step ahead so back-to-back reads stay fresh
  sector_buffer #(
    .WIDTH(16),
    .DEPTH(SECTOR_WORDS),
    .AW(8)
  ) u_buffer (
    .i_sys_clk(i_sys_clk),
    .i_clk_en(i_clk_en),
    .i_wr_en(state == S_FETCH && i_media_wvalid),
    .i_wr_addr(wr_idx),
    .i_wr_data(i_media_wdata),
    .i_rd_addr(next_rd_idx[7:0]),
    .o_rd_data(buf_q)
  );

  power_down_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_clk_en(i_clk_en),
    .i_arm(tmr_arm),
    .i_disarm(tmr_disarm),
    .i_wake(tmr_wake),
    .i_steps(sec_cnt),
    .o_power_down(o_power_down)
  );

endmodule // ata_read_idle_command_set
`default_nettype wire

// >>> test/ata_read_idle_command_set_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module ata_read_idle_command_set_assertions (
  // watched ports
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [2:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_eight_bit_mode,
  input wire logic i_media_done,
  input wire logic o_intrq,
  input wire logic o_transfer_request_line,
  input wire logic o_media_rd,
  input wire logic o_multiple_en,
  input wire logic [7:0] o_sectors_per_track,
  input wire logic [3:0] o_max_head
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  logic cmd;
  logic [7:0] sc, dh, op;
  assign cmd = i_wr && i_addr == 3'h7;
  // shadows of host writes
  always_ff @(posedge i_sys_clk) begin
    if (i_wr && i_addr == 3'h2) sc <= i_wdata[7:0];
    if (i_wr && i_addr == 3'h6) dh <= i_wdata[7:0];
    if (cmd) op <= i_wdata[7:0];
  end
  a_imm_done: assert property (
    cmd && (i_wdata[7:0] inside {8'h97, 8'hE3, 8'h95, 8'hE1} || i_wdata[7:4] == 4'h1)
    |-> ##2 o_intrq) else $error("no interrupt after immediate command");
  a_dma_abort: assert property (
    cmd && i_wdata[7:0] == 8'hC8 && i_eight_bit_mode |-> ##2 (o_intrq && !o_transfer_request_line))
    else $error("dma read not aborted");
  a_dma_quiet: assert property ($rose(o_intrq) |-> !o_transfer_request_line)
    else $error("interrupt during dma transfer");
  a_dma_end: assert property (
    $fell(o_transfer_request_line) |-> ##[1:3] (o_intrq ^ o_media_rd))
    else $error("no interrupt after dma transfer");
  a_geom_load: assert property (
    cmd && i_wdata[7:0] == 8'h91 |-> ##[2:3] (o_sectors_per_track == sc && o_max_head == dh[3:0]))
    else $error("geometry not loaded");
  a_media_stop: assert property (i_media_done |=> !o_media_rd)
    else $error("media request held after sector");
  a_verify_dry: assert property (op inside {8'h40, 8'h41} |-> !o_transfer_request_line)
    else $error("verify requested a transfer");
  a_multi_off: assert property (!o_multiple_en)
    else $error("multiple mode set");
endmodule // ata_read_idle_command_set_assertions
bind ata_read_idle_command_set ata_read_idle_command_set_assertions u_chk (.*);
`default_nettype wire

// >>> test/host_dma_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_dma_model (
  // pins
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic [15:0] i_data,
  input wire logic [3:0] i_gap,
  output logic o_grant_n,
  output logic o_strobe_n,
  // observed
  output int o_words,
  output logic [15:0] o_last
);
  initial begin
    o_grant_n = 1'b1;
    o_strobe_n = 1'b1;
    o_words = 0;
    forever begin
      @(posedge i_clk);
      o_grant_n <= !i_req;
      if (i_req && !o_grant_n) begin
        // sampled before its strobe pops it
        o_last <= i_data;
        o_words <= o_words + 1;
        o_strobe_n <= 1'b0;
        @(posedge i_clk) o_strobe_n <= 1'b1;
        repeat (5 + i_gap) @(posedge i_clk);
      end
    end
  end
endmodule // host_dma_model
`default_nettype wire

// >>> test/tb_ata_read_idle_command_set.sv
`timescale 1ns/10ps
`default_nettype none
module tb_ata_read_idle_command_set;
  logic clk = 0, resetn = 0, wr = 0, rd = 0, eight = 0, mval = 0, mdone = 0, merr = 0;
  logic grant_n, strobe_n, irq, req, mrd, pdown, multi;
  logic [2:0] addr = 0;
  logic [15:0] wdata = 0, mdata = 0, rdata, dma_data, last;
  logic [31:0] maddr;
  logic [7:0] spt, errsec = 0;
  logic [7:0] ops [5] = '{8'h95, 8'hE1, 8'h10, 8'h1F, 8'h5A};
  logic [3:0] mhead;
  logic ce = 1, srst = 0, keep = 0;
  int mismatches = 0, tests_run = 0, cyc = 0, words;
  ata_read_idle_command_set #(.STEP_CYCLES(8)) ata_read_idle_command_set_inst (
    .i_sys_clk(clk), .i_resetn(resetn), .i_clk_en(ce), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_intrq(irq), .o_transfer_request_line(req),
    .i_transfer_grant_line_n(grant_n), .i_io_read_strobe_n(strobe_n), .o_dma_data(dma_data),
    .o_media_rd(mrd), .o_media_addr(maddr), .i_media_wvalid(mval), .i_media_wdata(mdata),
    .i_media_done(mdone), .i_media_err(merr), .i_media_err_code(8'h11),
    .i_media_ecc(32'h44332211), .i_eight_bit_mode(eight), .i_soft_reset(srst),
    .i_keep_on_soft_reset(keep), .o_multiple_en(multi), .o_sectors_per_track(spt),
    .o_max_head(mhead), .o_power_down(pdown));
  host_dma_model host_dma_model_inst (.i_clk(clk), .i_req(req), .i_data(dma_data),
    .i_gap(4'h2), .o_grant_n(grant_n), .o_strobe_n(strobe_n), .o_words(words), .o_last(last));
  initial forever #5 clk = ~clk;
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [2:0] a, input logic [15:0] v);
    wr <= 1;
    addr <= a;
    wdata <= v;
    @(posedge clk) wr <= 0;
    @(posedge clk);
  endtask
  // upper byte masked by default
  task automatic get(input logic [2:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFF);
    rd <= 1;
    addr <= a;
    @(posedge clk) rd <= 0;
    @(posedge clk) chk(rdata & m, e);
  endtask
  task automatic wirq(input logic [7:0] st);
    int n = 0;
    while (irq !== 1'b1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    if (n == 9000) mismatches++;
    get(3'h7, {8'h0, st});
  endtask
  initial forever begin
    @(posedge clk iff mrd);
    for (int k = 0; k < 256; k++) begin
      mval <= 1;
      mdata <= {maddr[7:0], 8'(k)};
      @(posedge clk);
    end
    mval <= 0;
    mdata <= ~mdata;
    mdone <= 1;
    merr <= maddr[7:0] == errsec;
    @(posedge clk) mdone <= 0;
    merr <= 0;
  end
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1;
    @(posedge clk);
    chk({4'h0, spt, mhead}, 16'h03FF);
    chk({15'h0, multi}, 16'h0);
    put(3'h2, 16'h20);
    put(3'h6, 16'hA3);
    put(3'h7, 16'h91);
    wirq(8'h50);
    chk({4'h0, spt, mhead}, 16'h0203);
    put(3'h2, 16'h2);
    put(3'h7, 16'hE3);
    wirq(8'h50);
    chk({15'h0, pdown}, 16'h0);
    repeat (20) @(posedge clk);
    chk({15'h0, pdown}, 16'h1);
    put(3'h2, 16'h0);
    put(3'h7, 16'h97);
    wirq(8'h50);
    repeat (20) @(posedge clk);
    chk({15'h0, pdown}, 16'h0);
    foreach (ops[i]) begin
      put(3'h7, {8'h0, ops[i]});
      wirq(ops[i] == 8'h5A ? 8'h51 : 8'h50);
    end
    get(3'h1, 16'h04);
    put(3'h7, 16'h03);
    wirq(8'h50);
    get(3'h1, 16'h20);
    put(3'h3, 16'h1);
    put(3'h2, 16'h2);
    put(3'h7, 16'h20);
    for (int s = 1; s < 3; s++) begin
      wirq(8'h58);
      for (int k = 0; k < 256; k++) get(3'h0, {8'(s), 8'(k)}, 16'hFFFF);
    end
    repeat (3) @(posedge clk);
    get(3'h7, 16'h50);
    get(3'h3, 16'h2);
    put(3'h3, 16'h7);
    put(3'h7, 16'h22);
    wirq(8'h58);
    for (int k = 0; k < 256; k++) get(3'h0, {8'h7, 8'(k)}, 16'hFFFF);
    for (int k = 1; k < 5; k++) get(3'h0, 16'(8'h11 * k));
    put(3'h7, 16'hE4);
    wirq(8'h58);
    for (int k = 0; k < 256; k++) get(3'h0, {8'h7, 8'(k)}, 16'hFFFF);
    eight <= 1;
    put(3'h7, 16'hC8);
    wirq(8'h51);
    get(3'h1, 16'h04);
    eight <= 0;
    put(3'h3, 16'h5);
    put(3'h7, 16'hC8);
    wirq(8'h50);
    chk(16'(words), 16'd512);
    chk(last, 16'h06FF);
    get(3'h3, 16'h6);
    errsec <= 8'h2;
    put(3'h3, 16'h1);
    put(3'h2, 16'h3);
    put(3'h7, 16'h40);
    wirq(8'h51);
    get(3'h1, 16'h40);
    get(3'h2, 16'h2);
    get(3'h3, 16'h2);
    put(3'h7, 16'h03);
    wirq(8'h50);
    get(3'h1, 16'h11);
    ce <= 0;
    put(3'h3, 16'h9);
    ce <= 1;
    get(3'h3, 16'h2);
    put(3'h7, 16'hE4);
    {keep, srst} <= 2'b11;
    @(posedge clk) srst <= 0;
    get(3'h7, 16'h50);
    print_verdict();
  end
endmodule // tb_ata_read_idle_command_set
`default_nettype wire
